// file: fr_dev.sv
module fr_dev
  import fr_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       reset_in,
  input  wire logic [2:0] device_select_pins_in,
  input  wire logic       write_protect_in,
  output logic            hs_mode_out,
  fr_link_if.dev          lnk
);

  // ----------------------------------------
  // Types and state
  // ----------------------------------------
  typedef enum logic [1:0] {D_IDLE, D_RX, D_TX} fr_dst_t;
  typedef enum logic [1:0] {B_SADDR, B_WA1, B_WA2, B_DATA} fr_byte_t;

  typedef struct packed {
    logic [PIN_N-1:0]              s1;
    logic [PIN_N-1:0]              s2;
    logic [PIN_N-1:0]              s3;
    logic [PIN_N-1:0]              f;
    fr_dst_t                       st;
    fr_byte_t                      role;
    logic [3:0]                    cnt;
    logic [7:0]                    sh;
    logic [7:0]                    tx;
    logic [4:0]                    hi;
    logic [AW-1:0]                 addr;
    logic                          nack;
    logic                          oe;
    logic                          hs;
    logic [MEM_DEPTH-1:0][DATA_W-1:0] mem;
  } fr_dev_state_t;

  fr_dev_state_t    r;
  fr_dev_state_t    n;
  logic [PIN_N-1:0] pin_v;
  logic             rise;
  logic             fall;
  logic             sda_up;
  logic             sda_dn;
  logic             scl_hi;
  logic [7:0]       rd_byte;

  assign pin_v = {device_select_pins_in, write_protect_in, lnk.sda, lnk.scl};

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    n    = r;
    // Three-stage sampling of every pin
    n.s1 = pin_v;
    n.s2 = r.s1;
    n.s3 = r.s2;
    for (int i = 0; i < PIN_N; i++)
    begin
      n.f[i] = fr_filt(r.s2[i], r.s3[i], r.f[i]);
    end

    // Edge detection on filtered levels
    rise    = n.f[PIN_SCL] & ~r.f[PIN_SCL];
    fall    = ~n.f[PIN_SCL] & r.f[PIN_SCL];
    sda_up  = n.f[PIN_SDA] & ~r.f[PIN_SDA];
    sda_dn  = ~n.f[PIN_SDA] & r.f[PIN_SDA];
    scl_hi  = n.f[PIN_SCL] & r.f[PIN_SCL];
    rd_byte = r.mem[r.addr];

    // Start is watched in every state, even mid-byte
    if (sda_dn && scl_hi)
    begin
      n.st   = D_RX;
      n.role = B_SADDR;
      n.cnt  = 4'h0;
      n.oe   = 1'b0;
    end
    else if (sda_up && scl_hi)
    begin
      // Stop ends any operation and leaves fast mode
      n.st = D_IDLE;
      n.oe = 1'b0;
      n.hs = 1'b0;
    end
    else if (rise && r.st != D_IDLE)
    begin
      // Inputs are latched on the rising clock
      if (r.cnt < 4'h8)
        n.sh = {r.sh[6:0], n.f[PIN_SDA]};
      // Ninth clock of a read byte carries the master's answer
      if (r.st == D_TX && r.cnt == 4'h8)
        n.nack = n.f[PIN_SDA];
      if (r.cnt < 4'h9)
        n.cnt = r.cnt + 4'h1;
    end
    else if (fall)
    begin
      case (r.st)
        D_RX:
        begin
          if (r.cnt == 4'h8)
          begin
            case (r.role)
              B_SADDR:
              begin
                if (r.sh[7:3] == MASTER_CODE)
                begin
                  // No answer; wait for the repeated start
                  n.hs = 1'b1;
                  n.st = D_IDLE;
                end
                else if (r.sh[7:4] == DEV_TYPE_CODE
                         && r.sh[3:1] == r.f[PIN_SEL2:PIN_SEL0])
                begin
                  n.oe   = 1'b1;
                  n.nack = 1'b0;
                  if (r.sh[0])
                    n.st = D_TX;
                  else
                    n.role = B_WA1;
                end
                else
                  n.st = D_IDLE;
              end
              B_WA1:
              begin
                // Upper three bits of the first word byte are dropped
                n.hi   = r.sh[4:0];
                n.oe   = 1'b1;
                n.role = B_WA2;
              end
              B_WA2:
              begin
                n.addr = {r.hi, r.sh};
                n.oe   = 1'b1;
                n.role = B_DATA;
              end
              B_DATA:
              begin
                // Protected bytes still advance and are acknowledged
                if (!r.f[PIN_WP])
                  n.mem[r.addr] = r.sh;
                n.addr = r.addr + 1'b1;
                n.oe   = 1'b1;
              end
              default:
                n.st = D_IDLE;
            endcase
          end
          else if (r.cnt == 4'h9)
          begin
            n.oe  = 1'b0;
            n.cnt = 4'h0;
          end
        end
        D_TX:
        begin
          if (r.cnt == 4'h9)
          begin
            if (r.nack)
            begin
              // Master declined: release and wait for stop
              n.st = D_IDLE;
              n.oe = 1'b0;
            end
            else
            begin
              // Outputs change on the falling clock
              n.tx  = {rd_byte[6:0], 1'b0};
              n.oe  = ~rd_byte[7];
              n.cnt = 4'h0;
            end
          end
          else if (r.cnt == 4'h8)
          begin
            n.oe   = 1'b0;
            n.addr = r.addr + 1'b1;
          end
          else if (r.cnt != 4'h0)
          begin
            n.oe = ~r.tx[7];
            n.tx = {r.tx[6:0], 1'b0};
          end
        end
        default:
        begin
          n.oe = 1'b0;
        end
      endcase
    end

    // Memory survives reset, address returns to zero; nonvolatile array
    if (reset_in)
    begin
      n.s1   = PIN_RST;
      n.s2   = PIN_RST;
      n.s3   = PIN_RST;
      n.f    = PIN_RST;
      n.st   = D_IDLE;
      n.role = B_SADDR;
      n.cnt  = 4'h0;
      n.sh   = 8'h00;
      n.tx   = 8'h00;
      n.hi   = 5'h00;
      n.addr = '0;
      n.nack = 1'b0;
      n.oe   = 1'b0;
      n.hs   = 1'b0;
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk_in)
  begin
    r <= n;
  end

  // Outputs straight from state flops
  assign lnk.dev_sda_oe = r.oe;
  assign hs_mode_out    = r.hs;

endmodule : fr_dev

// file: fr_fifo.sv
module fr_fifo
  import fr_pkg::*;
#(
  parameter int WIDTH = DATA_W,
  parameter int DEPTH = FIFO_DEPTH
)
(
  input  wire logic             clk_in,
  input  wire logic             reset_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  output logic      [WIDTH-1:0] out_data_out,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in
);

  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wp;
    logic [PW-1:0]               rp;
    logic [PW:0]                 cnt;
    logic                        rdy;
  } fr_fifo_state_t;

  fr_fifo_state_t r;
  fr_fifo_state_t n;
  logic           push;
  logic           pop;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    n    = r;
    push = in_valid_in & r.rdy;
    pop  = out_ready_in & (r.cnt != '0);
    if (push)
    begin
      n.mem[r.wp] = in_data_in;
      n.wp        = r.wp + 1'b1;
    end
    if (pop)
      n.rp = r.rp + 1'b1;
    n.cnt = r.cnt + (PW+1)'(push) - (PW+1)'(pop);
    // Ready is registered so the source sees a clean level
    n.rdy = (n.cnt != (PW+1)'(DEPTH));
    if (reset_in)
    begin
      n.wp  = '0;
      n.rp  = '0;
      n.cnt = '0;
      n.rdy = 1'b0;
    end
  end

  always_ff @(posedge clk_in)
  begin
    r <= n;
  end

  assign in_ready_out  = r.rdy;
  assign out_valid_out = (r.cnt != '0);
  assign out_data_out  = r.mem[r.rp];

endmodule : fr_fifo

// file: fr_host.sv
module fr_host
  import fr_pkg::*;
(
  input  wire logic             clk_in,
  input  wire logic             reset_in,
  input  wire logic             cmd_valid_in,
  input  wire logic             cmd_read_in,
  input  wire logic             cmd_cur_in,
  input  wire logic [2:0]       cmd_sel_in,
  input  wire logic [AW-1:0]    cmd_addr_in,
  input  wire logic [LEN_W-1:0] cmd_len_in,
  output logic                  cmd_ready_out,
  input  wire logic [7:0]       wr_data_in,
  input  wire logic             wr_valid_in,
  output logic                  wr_ready_out,
  output logic      [7:0]       rd_data_out,
  output logic                  rd_valid_out,
  output logic                  done_out,
  output logic                  nack_out,
  fr_link_if.host               lnk
);

  // ----------------------------------------
  // Types and state
  // ----------------------------------------
  typedef enum logic [2:0] {H_IDLE, H_START, H_BYTE, H_LOAD, H_STOP} fr_hst_t;
  typedef enum logic [2:0] {G_SADDR_W, G_WA1, G_WA2, G_WDATA, G_SADDR_R, G_RDATA} fr_stage_t;

  typedef struct packed {
    logic [2:0]       s;
    logic             sda_f;
    fr_hst_t          st;
    fr_stage_t        stage;
    logic [DIV_W-1:0] div;
    logic [1:0]       q;
    logic [3:0]       bitn;
    logic [7:0]       sh;
    logic             ackb;
    logic             rd;
    logic [2:0]       sel;
    logic [AW-1:0]    addr;
    logic [LEN_W-1:0] left;
    logic             scl_oe;
    logic             sda_oe;
    logic             ready;
    logic [7:0]       rdata;
    logic             rvalid;
    logic             done;
    logic             nack;
  } fr_host_state_t;

  fr_host_state_t r;
  fr_host_state_t n;
  logic           tick;
  logic           tx;
  logic           pop;
  logic [7:0]     f_data;
  logic           f_valid;

  // Write data waits here; an empty buffer stalls the bus
  fr_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_in        (clk_in),
    .reset_in      (reset_in),
    .in_data_in    (wr_data_in),
    .in_valid_in   (wr_valid_in),
    .in_ready_out  (wr_ready_out),
    .out_data_out  (f_data),
    .out_valid_out (f_valid),
    .out_ready_in  (pop)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    n        = r;
    n.rvalid = 1'b0;
    n.done   = 1'b0;
    n.s      = {r.s[1:0], lnk.sda};
    n.sda_f  = fr_filt(r.s[1], r.s[2], r.sda_f);
    tick     = (r.div == DIV_W'(QUARTER_CYC - 1));
    n.div    = tick ? '0 : r.div + 1'b1;
    tx       = (r.stage != G_RDATA);
    pop      = (r.st == H_LOAD) && f_valid;
    case (r.st)
      H_IDLE:
      begin
        n.ready = 1'b1;
        if (cmd_valid_in && r.ready)
        begin
          n.ready = 1'b0;
          n.rd    = cmd_read_in;
          n.sel   = cmd_sel_in;
          n.addr  = cmd_addr_in;
          n.left  = cmd_len_in;
          n.nack  = 1'b0;
          n.q     = 2'h0;
          n.st    = H_START;
          n.stage = (cmd_read_in && cmd_cur_in) ? G_SADDR_R : G_SADDR_W;
        end
      end
      H_START:
        if (tick)
        begin
          n.q = r.q + 2'h1;
          case (r.q)
            2'h0: n.sda_oe = 1'b0;
            2'h1: n.scl_oe = 1'b0;
            2'h2: n.sda_oe = 1'b1;
            default:
            begin
              n.scl_oe = 1'b1;
              n.st     = H_BYTE;
              n.bitn   = 4'h0;
              n.sh     = {DEV_TYPE_CODE, r.sel, r.stage == G_SADDR_R};
            end
          endcase
        end
      H_LOAD:
        if (f_valid)
        begin
          n.sh   = f_data;
          n.st   = H_BYTE;
          n.bitn = 4'h0;
          n.q    = 2'h0;
        end
      H_BYTE:
        if (tick)
        begin
          n.q = r.q + 2'h1;
          case (r.q)
            2'h0:
              // Release after eight bits; ack reads unless last
              n.sda_oe = (r.bitn < 4'h8) ? (tx & ~r.sh[7])
                                         : (~tx & (r.left != LEN_W'(1)));
            2'h1: n.scl_oe = 1'b0;
            2'h2:
              if (r.bitn < 4'h8)
                n.sh = {r.sh[6:0], r.sda_f};
              else
                n.ackb = r.sda_f;
            default:
            begin
              n.scl_oe = 1'b1;
              // Let go with the clock after bit eight and the ack, so
              // the other end takes the line without both pulling low
              if (r.bitn >= 4'h7)
                n.sda_oe = 1'b0;
              if (r.bitn < 4'h8)
                n.bitn = r.bitn + 4'h1;
              else if (tx && r.ackb)
              begin
                n.nack = 1'b1;
                n.st   = H_STOP;
              end
              else
              begin
                n.bitn = 4'h0;
                case (r.stage)
                  G_SADDR_W:
                  begin
                    n.stage = G_WA1;
                    n.sh    = {HI_PAD, r.addr[AW-1:8]};
                  end
                  G_WA1:
                  begin
                    n.stage = G_WA2;
                    n.sh    = r.addr[7:0];
                  end
                  G_WA2:
                  begin
                    n.stage = r.rd ? G_SADDR_R : G_WDATA;
                    n.q     = 2'h0;
                    n.st    = r.rd ? H_START : (r.left == '0 ? H_STOP : H_LOAD);
                  end
                  G_WDATA:
                  begin
                    n.left = r.left - 1'b1;
                    n.st   = (r.left == LEN_W'(1)) ? H_STOP : H_LOAD;
                  end
                  G_SADDR_R:
                  begin
                    n.stage = G_RDATA;
                    n.sh    = 8'h00;
                  end
                  default:
                  begin
                    n.rdata  = r.sh;
                    n.rvalid = 1'b1;
                    n.left   = r.left - 1'b1;
                    if (r.left == LEN_W'(1))
                      n.st = H_STOP;
                  end
                endcase
              end
            end
          endcase
        end
      H_STOP:
        if (tick)
        begin
          n.q = r.q + 2'h1;
          case (r.q)
            2'h0: n.sda_oe = 1'b1;
            2'h1: n.scl_oe = 1'b0;
            2'h2: n.sda_oe = 1'b0;
            default:
            begin
              n.st   = H_IDLE;
              n.done = 1'b1;
            end
          endcase
        end
      default:
        n.st = H_IDLE;
    endcase
    if (reset_in)
    begin
      n        = '0;
      n.s      = 3'h7;
      n.sda_f  = 1'b1;
      n.st     = H_IDLE;
      n.stage  = G_SADDR_W;
    end
  end

  always_ff @(posedge clk_in)
  begin
    r <= n;
  end

  assign lnk.host_scl_oe = r.scl_oe;
  assign lnk.host_sda_oe = r.sda_oe;
  assign cmd_ready_out   = r.ready;
  assign rd_data_out     = r.rdata;
  assign rd_valid_out    = r.rvalid;
  assign done_out        = r.done;
  assign nack_out        = r.nack;

endmodule : fr_host

// file: fr_link_if.sv
// ----------------------------------------
// Two-wire link, open-drain with pull-ups
// ----------------------------------------
interface fr_link_if;
  logic host_scl_oe;
  logic host_sda_oe;
  logic dev_sda_oe;
  logic scl;
  logic sda;

  // Wired-AND: any enable pulls the line low
  assign scl = ~host_scl_oe;
  assign sda = ~(host_sda_oe | dev_sda_oe);

  modport dev  (input scl, input sda, output dev_sda_oe);
  modport host (input scl, input sda, output host_scl_oe, output host_sda_oe);
endinterface : fr_link_if

// file: fr_link_sva.sv
// ------------------------------
// Checker on the main link
// ------------------------------
module fr_link_sva
  import fr_pkg::*;
(
  input wire logic       clk_in,
  input wire logic       reset_in,
  input wire logic       scl,
  input wire logic       sda,
  input wire logic       host_sda_oe,
  input wire logic       dev_sda_oe,
  input wire logic [2:0] device_select_pins_in
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (reset_in);

  logic       scl_q, sda_q, fr_r, rd_r, nak_r;
  logic [3:0] cnt_r;
  logic [2:0] byt_r;
  logic [7:0] sh_r;
  // Wire events; the lines are clean in simulation, so no filter
  wire st_w  = scl & scl_q & sda_q & ~sda;
  wire sp_w  = scl & scl_q & ~sda_q & sda;
  wire ri_w  = scl & ~scl_q & fr_r;
  wire ack_w = ri_w & (cnt_r == 4'h8);
  wire hit_w = (sh_r[7:4] == DEV_TYPE_CODE) & (sh_r[3:1] == device_select_pins_in);

  // Bit and byte position; a repeated start restarts the count
  always_ff @(posedge clk_in)
  begin
    scl_q <= scl;
    sda_q <= sda;
    fr_r  <= !reset_in && !sp_w && (fr_r || st_w);
    nak_r <= !reset_in && !sp_w && !st_w && (nak_r || (ack_w && rd_r && byt_r != 3'h0 && sda));
    if (st_w)
    begin
      cnt_r <= 4'h0;
      byt_r <= 3'h0;
      rd_r  <= 1'b0;
    end
    else if (ri_w)
    begin
      cnt_r <= (cnt_r == 4'h9) ? 4'h1 : cnt_r + 4'h1;
      sh_r  <= (cnt_r == 4'h8) ? sh_r : {sh_r[6:0], sda};
      rd_r  <= (cnt_r == 4'h7 && byt_r == 3'h0) ? sda : rd_r;
      byt_r <= byt_r + {2'h0, ack_w && byt_r != 3'h7};  // Saturates, only zero matters
    end
  end

  dev_edge_a : assert property ($changed(dev_sda_oe) |-> !scl)
    else $error("Device moved data with clock high");
  no_clash_a : assert property (!(dev_sda_oe && host_sda_oe))
    else $error("Both ends pull data");
  wr_slot_a : assert property (dev_sda_oe && !rd_r |-> cnt_r >= 4'h8)
    else $error("Device drove outside ack slot");
  addr_ack_a : assert property (ack_w && byt_r == 3'h0 |-> sda == !hit_w)
    else $error("Wrong address acknowledge");
  data_ack_a : assert property (ack_w && byt_r != 3'h0 && !rd_r |-> !sda)
    else $error("Written byte not acknowledged");
  rd_free_a : assert property (ack_w && byt_r != 3'h0 && rd_r |-> !dev_sda_oe)
    else $error("Device held data in read ack slot");
  nak_idle_a : assert property (nak_r |-> !dev_sda_oe)
    else $error("Device drove after master no-ack");
  idle_scl_a : assert property (!fr_r |-> scl)
    else $error("Clock moved outside a frame");
  start_go_a : assert property (st_w |-> ##[1:100] !scl)
    else $error("No clocking after start");
endmodule : fr_link_sva

// file: fr_pkg.sv
package fr_pkg;

  // ----------------------------------------
  // Array and data shape
  // ----------------------------------------
  localparam int AW         = 13;
  localparam int MEM_DEPTH  = 8192;
  localparam int DATA_W     = 8;
  localparam int LEN_W      = 14;
  localparam int FIFO_DEPTH = 32;

  // ----------------------------------------
  // Slave address coding
  // ----------------------------------------
  localparam logic [3:0] DEV_TYPE_CODE = 4'h5;  // Arbitrary value
  localparam logic [4:0] MASTER_CODE   = 5'h01;
  localparam logic [2:0] HI_PAD        = 3'h0;

  // ----------------------------------------
  // Pin sampling vector of the device end
  // ----------------------------------------
  localparam int         PIN_N    = 6;
  localparam int         PIN_SCL  = 0;
  localparam int         PIN_SDA  = 1;
  localparam int         PIN_WP   = 2;
  localparam int         PIN_SEL0 = 3;
  localparam int         PIN_SEL2 = 5;
  localparam logic [5:0] PIN_RST  = 6'h03;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int SCL_PERIOD_NS = 2500;
  // Least quarter period, rounded up
  localparam int QUARTER_CYC   = (SCL_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);
  localparam int DIV_W         = 7;

  // Change counts once second and third stage agree
  function automatic logic fr_filt(input logic s2, input logic s3, input logic f);
    fr_filt = (s2 == s3) ? s3 : f;
  endfunction : fr_filt

endpackage : fr_pkg

// file: i2c_serial_fram_slave_test.sv
// ------------------------------
// Host and device face to face
// ------------------------------
module i2c_serial_fram_slave_test;
  timeunit 1ns;
  timeprecision 1ps;
  import fr_pkg::*;

  localparam logic [7:0] HS_CODE = {MASTER_CODE, 3'h3};
  logic             clk_in, reset_in, cmd_valid, cmd_read, cmd_cur, cmd_ready;
  logic [2:0]       cmd_sel, sel_pins;
  logic [AW-1:0]    cmd_addr;
  logic [LEN_W-1:0] cmd_len;
  logic [7:0]       wr_data, rd_data;
  logic             wr_valid, wr_ready, rd_valid, done, nack, wp, hs, hs2;
  logic [7:0]       got[$];
  int               error_cnt = 0;
  int               compares = 0;

  fr_link_if lnk();
  fr_link_if lnk2();
  fr_host fr_host_inst (.clk_in(clk_in), .reset_in(reset_in), .cmd_valid_in(cmd_valid),
    .cmd_read_in(cmd_read), .cmd_cur_in(cmd_cur), .cmd_sel_in(cmd_sel), .cmd_addr_in(cmd_addr),
    .cmd_len_in(cmd_len), .cmd_ready_out(cmd_ready), .wr_data_in(wr_data), .wr_valid_in(wr_valid),
    .wr_ready_out(wr_ready), .rd_data_out(rd_data), .rd_valid_out(rd_valid), .done_out(done),
    .nack_out(nack), .lnk(lnk.host));
  fr_dev fr_dev_inst (.clk_in(clk_in), .reset_in(reset_in), .device_select_pins_in(sel_pins),
    .write_protect_in(wp), .hs_mode_out(hs), .lnk(lnk.dev));
  // Spare device on a bench-driven link for the master code
  fr_dev fr_dev_hs_inst (.clk_in(clk_in), .reset_in(reset_in), .device_select_pins_in(sel_pins),
    .write_protect_in(wp), .hs_mode_out(hs2), .lnk(lnk2.dev));
  fr_link_sva fr_link_sva_inst (.clk_in(clk_in), .reset_in(reset_in), .scl(lnk.scl), .sda(lnk.sda),
    .host_sda_oe(lnk.host_sda_oe), .dev_sda_oe(lnk.dev_sda_oe), .device_select_pins_in(sel_pins));

  // Clock, 8 ns
  initial
  begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end

  task automatic tick();
    @(posedge clk_in);
    #1;
  endtask : tick

  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    compares++;
    if (seen !== want)
    begin
      error_cnt++;
      $display("mismatch at %0t: saw %h, expected %h", $time, seen, want);
    end
  endtask : check

  task automatic conclude();
    $display("compares %0d, errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : conclude

  task automatic stall();
    error_cnt++;
    $display("mismatch at %0t: wait ran out", $time);
    conclude();
  endtask : stall

  // FIFO is far from full here, so ready is checked, not waited for
  task automatic push(input logic [7:0] d[$]);
    foreach (d[i])
    begin
      check({7'h0, wr_ready}, 8'h01);
      wr_data = d[i];
      wr_valid = 1'b1;
      tick();
    end
    wr_valid = 1'b0;
  endtask : push

  // Offer bytes while idle; data only moves on once a byte is taken
  task automatic fill(output int n);
    n = 0;
    wr_valid = 1'b1;
    repeat (40)
    begin
      wr_data = n[7:0];
      if (wr_ready === 1'b1) n++;
      tick();
    end
    wr_valid = 1'b0;
  endtask : fill

  // One command; bound covers about 14 bytes on the wire, over twice the longest (6 bytes)
  task automatic run(input logic rd, input logic cur, input logic [2:0] s, input logic [AW-1:0] a,
                     input logic [LEN_W-1:0] n);
    int k;
    got.delete();
    {cmd_read, cmd_cur, cmd_sel, cmd_addr, cmd_len} = {rd, cur, s, a, n};
    cmd_valid = 1'b1;
    for (k = 0; cmd_ready !== 1'b1; k++)
    begin
      if (k > 99) stall();
      tick();
    end
    tick();
    cmd_valid = 1'b0;
    for (k = 0; done !== 1'b1; k++)
    begin
      if (k > 40000) stall();
      if (rd_valid === 1'b1) got.push_back(rd_data);
      tick();
    end
  endtask : run

  // Bench link clock: 10 cycles low, 10 high, 160 ns a bit
  task automatic bb(input logic c, input logic d, input int n);
    lnk2.host_scl_oe = c;
    lnk2.host_sda_oe = d;
    repeat (n) tick();
  endtask : bb

  // Main sequence
  initial
  begin
    int n;
    {cmd_valid, cmd_read, cmd_cur, cmd_sel, cmd_addr, cmd_len, wr_data, wr_valid} = '0;
    {wp, lnk2.host_scl_oe, lnk2.host_sda_oe} = '0;
    sel_pins = 3'h5;
    reset_in = 1'b1;
    repeat (4) tick();
    reset_in = 1'b0;
    run(1'b0, 1'b0, 3'h2, 13'h0000, 14'h0000);
    check({7'h0, nack}, 8'h01);
    push({8'ha1, 8'hb2, 8'hc3});
    run(1'b0, 1'b0, 3'h5, 13'h1fff, 14'h0003);
    check({7'h0, nack}, 8'h00);
    run(1'b1, 1'b0, 3'h5, 13'h1fff, 14'h0002);
    check(8'(got.size()), 8'h02);
    check(got[0], 8'ha1);
    check(got[1], 8'hb2);
    run(1'b1, 1'b1, 3'h5, 13'h0000, 14'h0001);
    check(got[0], 8'hc3);
    // Protected write, then read back with new select pins
    wp = 1'b1;
    sel_pins = 3'h3;
    push({8'h5a});
    run(1'b0, 1'b0, 3'h3, 13'h0000, 14'h0001);
    wp = 1'b0;
    run(1'b1, 1'b0, 3'h3, 13'h0000, 14'h0001);
    check(got[0], 8'hb2);
    check({7'h0, hs}, 8'h00);
    // Master code: no ack, high speed held over restart
    bb(1'b0, 1'b1, 10);
    for (int i = 7; i >= 0; i--)
    begin
      bb(1'b1, lnk2.host_sda_oe, 5);
      bb(1'b1, ~HS_CODE[i], 5);
      bb(1'b0, ~HS_CODE[i], 10);
    end
    bb(1'b1, lnk2.host_sda_oe, 5);
    bb(1'b1, 1'b0, 5);
    bb(1'b0, 1'b0, 10);
    check({7'h0, lnk2.sda}, 8'h01);
    bb(1'b0, 1'b1, 10);
    check({7'h0, hs2}, 8'h01);
    bb(1'b0, 1'b0, 10);
    check({7'h0, hs2}, 8'h00);
    // Write FIFO: fill till refused; a mid-run reset must empty it
    fill(n);
    check(n[7:0], 8'h20);
    check({7'h0, wr_ready}, 8'h00);
    reset_in = 1'b1;
    tick();
    check({5'h0, hs, cmd_ready, wr_ready}, 8'h00);
    reset_in = 1'b0;
    repeat (2) tick();
    check({5'h0, hs, cmd_ready, wr_ready}, 8'h03);
    fill(n);
    check(n[7:0], 8'h20);
    conclude();
  end
endmodule : i2c_serial_fram_slave_test
